// ### rtl/bsod_diag.sv
// Operation
// (RQ1) switch-open: above high threshold raises fault
// (RQ2) switch-open: below low raises fault, window passes
// (RQ3) switch-open: cell enable = switch and unipolar
// (RQ4) switch-open: block, aux, diagnostics forced off
// (RQ5) switch-open: alternate path, single sample
// (RQ6) sense-wire modes force bipolar acquisition
// (RQ7) sense-wire modes close nonadjacent switches only
// (RQ8) odd pattern 1555h, even pattern 2AAAh
// (RQ9) bipolar and above-top positions masked off
// (RQ10) host waits settling before starting scan
// (RQ11) sense-wire: outside window raises fault
// (RQ12) sense-wire: cell enable = forced switch, unipolar
// (RQ13) sense-wire: block, aux, diagnostics off, one sample
// (RQ14) sense-wire: alternate path selected
// (RQ15) overrides last only for the scan; switch pattern and bipolar are forced whenever the mode code is 110 or 111
// (RQ16) codes 101 open, 110 odd, 111 even
// (RQ17) alerts cleared at start, written at end
// (RQ18) summary is OR of alerts at end
// (RQ19) unmeasured channels never raise alerts
`timescale 1ns/10ps
module bsod_diag
  import bsod_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic [5:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  output logic               irq,
  output bsod_acq_cfg_s      acqCfg,
  output logic               scanRequest,
  input  wire bsod_result_s  result,
  input  wire logic          acqDone
);
  // software registers
  logic [2:0]    scan_config_r,    scan_config_nxt;    // selected scan mode
  logic          altUser_r,    altUser_nxt;    // user path select
  logic [3:0]    ovsUser_r,    ovsUser_nxt;    // user oversample
  logic [13:0]   swUser_r,     swUser_nxt;     // user switch mask
  logic [13:0]   polarity_r,   polarity_nxt;   // bipolar flags
  logic [15:0]   cellUser_r,   cellUser_nxt;   // user cell enables
  logic [5:0]    auxUser_r,    auxUser_nxt;    // user aux enables
  logic [7:0]    diagUser_r,   diagUser_nxt;   // user selectors
  logic [13:0]   lowThr_r,     lowThr_nxt;     // low threshold
  logic [13:0]   highThr_r,    highThr_nxt;    // high threshold
  logic [3:0]    highest_cell_position_r,    highest_cell_position_nxt;    // highest cell index
  logic [13:0]   alerts_r,     alerts_nxt;     // fault alerts
  logic          summary_r,    summary_nxt;    // fault summary
  logic [1:0]    irqStat_r,    irqStat_nxt;    // sticky events
  logic [1:0]    irqMask_r,    irqMask_nxt;    // event mask
  // sequencer state
  bsod_state_e   state_r,      state_nxt;      // scan sequencer
  logic [2:0]    scanMode_r,   scanMode_nxt;   // mode of running scan
  logic [13:0]   pending_r,    pending_nxt;    // faults gathered
  logic          doneFlag_r,   doneFlag_nxt;   // scan complete flag
  logic          scanReq_r,    scanReq_nxt;    // start pulse out
  bsod_acq_cfg_s acqCfg_r,     acqCfg_nxt;     // effective settings
  // bus handshake
  logic          ack_r,        ack_nxt;        // answer cycle
  logic [31:0]   rdata_r,      rdata_nxt;      // read data
  // helpers
  logic          busReq;                       // read or write pending
  logic          wrTake;                       // write takes effect
  logic          startPulse;                   // accepted start
  logic          diagActNxt;                   // override next cycle
  logic          senseSelNxt;                  // switches forced next
  logic [13:0]   topMask;                      // positions in use
  logic [13:0]   faultHit;                     // fault per channel
  logic [13:0]   sensePat;                     // masked forced pattern
  assign busReq = avs_read | avs_write;
  assign wrTake = avs_write & ack_r;
  assign avs_waitrequest = busReq & ~ack_r;
  assign avs_readdata = rdata_r;
  assign irq = |(irqStat_r & irqMask_r);
  assign acqCfg = acqCfg_r;
  assign scanRequest = scanReq_r;
  // per-channel position mask, window compare and measured gate
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign topMask[i] = (4'(i) <= highest_cell_position_r);
    // (RQ9) mask bipolar and unused
    assign sensePat[i] = (scan_config_nxt == CFG_ODD ? SW_ODD_PAT[i]
                          : SW_EVEN_PAT[i]) & ~polarity_r[i] & topMask[i];
    // (RQ1) (RQ2) (RQ11) (RQ19) window on measured only
    assign faultHit[i] = result.valid && (result.channel == 4'(i))
                         && (state_r == ST_SCAN)
                         && bsod_is_diag(scanMode_r)
                         && acqCfg_r.cellEn[i]
                         && ((result.data > highThr_r)
                             || (result.data < lowThr_r));
  end
  // next-state logic for registers, bus and sequencer
  always_comb begin
    scan_config_nxt  = scan_config_r;
    altUser_nxt  = altUser_r;
    ovsUser_nxt  = ovsUser_r;
    swUser_nxt   = swUser_r;
    polarity_nxt = polarity_r;
    cellUser_nxt = cellUser_r;
    auxUser_nxt  = auxUser_r;
    diagUser_nxt = diagUser_r;
    lowThr_nxt   = lowThr_r;
    highThr_nxt  = highThr_r;
    highest_cell_position_nxt  = highest_cell_position_r;
    alerts_nxt   = alerts_r;
    summary_nxt  = summary_r;
    irqStat_nxt  = irqStat_r;
    irqMask_nxt  = irqMask_r;
    state_nxt    = state_r;
    scanMode_nxt = scanMode_r;
    pending_nxt  = pending_r;
    doneFlag_nxt = doneFlag_r;
    scanReq_nxt  = 1'b0;
    ack_nxt      = busReq & ~ack_r;
    rdata_nxt    = rdata_r;
    startPulse   = 1'b0;
    // read data prepared one cycle ahead of the answer
    if (avs_read && !ack_r) begin
      rdata_nxt = 32'h0000_0000;
      case (avs_address)
        OFF_SCAN_CTRL: begin
          rdata_nxt[SC_CFG_LSB +: 3] = scan_config_r;
          rdata_nxt[SC_ALT_BIT]      = altUser_r;
          rdata_nxt[SC_OVS_LSB +: 4] = ovsUser_r;
          rdata_nxt[SC_BUSY_BIT]     = (state_r != ST_IDLE);
          rdata_nxt[SC_DONE_BIT]     = doneFlag_r;
        end
        OFF_SW_EN:    rdata_nxt[13:0] = swUser_r;
        OFF_POLARITY: rdata_nxt[13:0] = polarity_r;
        OFF_CELL_EN:  rdata_nxt[15:0] = cellUser_r;
        OFF_AUX_EN:   rdata_nxt[5:0]  = auxUser_r;
        OFF_DIAG_SEL: rdata_nxt[7:0]  = diagUser_r;
        OFF_LOW_THR:  rdata_nxt[13:0] = lowThr_r;
        OFF_HIGH_THR: rdata_nxt[13:0] = highThr_r;
        OFF_TOP_CELL: rdata_nxt[3:0]  = highest_cell_position_r;
        OFF_ALERTS: begin
          rdata_nxt[13:0]          = alerts_r;
          rdata_nxt[ALERT_SUM_BIT] = summary_r;
        end
        OFF_IRQ_STAT: rdata_nxt[1:0]  = irqStat_r;
        OFF_IRQ_MASK: rdata_nxt[1:0]  = irqMask_r;
        default:      rdata_nxt = 32'h0000_0000;  // unmapped reads zero
      endcase
    end
    // writes land in the cycle waitrequest is low
    if (wrTake) begin
      case (avs_address)
        OFF_SCAN_CTRL: begin
          // (RQ16) mode code field
          scan_config_nxt = avs_writedata[SC_CFG_LSB +: 3];
          altUser_nxt = avs_writedata[SC_ALT_BIT];
          ovsUser_nxt = avs_writedata[SC_OVS_LSB +: 4];
          startPulse  = avs_writedata[SC_START_BIT]
                        && (state_r == ST_IDLE);
        end
        OFF_SW_EN:    swUser_nxt   = avs_writedata[13:0];
        OFF_POLARITY: polarity_nxt = avs_writedata[13:0];
        OFF_CELL_EN:  cellUser_nxt = avs_writedata[15:0];
        OFF_AUX_EN:   auxUser_nxt  = avs_writedata[5:0];
        OFF_DIAG_SEL: diagUser_nxt = avs_writedata[7:0];
        OFF_LOW_THR:  lowThr_nxt   = avs_writedata[13:0];
        OFF_HIGH_THR: highThr_nxt  = avs_writedata[13:0];
        OFF_TOP_CELL: highest_cell_position_nxt  = avs_writedata[3:0];
        OFF_ALERTS: begin  // summary cleared by writing zero
          if (!avs_writedata[ALERT_SUM_BIT]) begin
            summary_nxt = 1'b0;
          end
        end
        OFF_IRQ_STAT: irqStat_nxt = irqStat_r & ~avs_writedata[1:0];
        OFF_IRQ_MASK: irqMask_nxt = avs_writedata[1:0];
        default: ;                               // unmapped writes dropped
      endcase
    end
    // scan sequencer
    case (state_r)
      ST_IDLE: begin
        if (startPulse) begin
          state_nxt    = ST_SCAN;
          scanMode_nxt = scan_config_nxt;
          scanReq_nxt  = 1'b1;
          pending_nxt  = 14'h0000;
          doneFlag_nxt = 1'b0;
          // (RQ17) clear alerts on request
          if (bsod_is_diag(scan_config_nxt)) begin
            alerts_nxt = 14'h0000;
          end
        end
      end
      ST_SCAN: begin
        pending_nxt = pending_r | faultHit;
        if (acqDone) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt    = ST_IDLE;
        doneFlag_nxt = 1'b1;
        irqStat_nxt[IRQ_DONE_BIT] = 1'b1;        // set beats clear
        if (bsod_is_diag(scanMode_r)) begin
          // (RQ17) results written at end
          alerts_nxt  = pending_r;
          // (RQ18) summary from all alerts
          summary_nxt = |pending_r;
          irqStat_nxt[IRQ_FAULT_BIT] |= (|pending_r);  // set beats clear
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // effective acquisition settings, user values by default
    diagActNxt  = (state_nxt != ST_IDLE) && bsod_is_diag(scanMode_nxt);
    senseSelNxt = bsod_is_sense(scan_config_nxt)
                  || (diagActNxt && bsod_is_sense(scanMode_nxt));
    acqCfg_nxt.cellEn   = cellUser_nxt;
    acqCfg_nxt.auxEn    = auxUser_nxt;
    acqCfg_nxt.diagSel  = diagUser_nxt;
    acqCfg_nxt.altPath  = altUser_nxt;
    acqCfg_nxt.ovSample = ovsUser_nxt;
    acqCfg_nxt.swEn     = swUser_nxt;
    acqCfg_nxt.bipolar  = 1'b0;
    // (RQ7) (RQ8) odd or even pattern closed
    if (senseSelNxt) begin
      acqCfg_nxt.swEn    = sensePat;
      // (RQ6) bipolar for near-zero readings
      acqCfg_nxt.bipolar = 1'b1;
    end
    // (RQ15) overrides only while scanning
    if (diagActNxt) begin
      // (RQ3) (RQ12) measure active unipolar positions
      acqCfg_nxt.cellEn[13:0]  = acqCfg_nxt.swEn & ~polarity_nxt;
      // (RQ4) (RQ13) block, aux, selectors off
      acqCfg_nxt.cellEn[15:14] = 2'b00;
      acqCfg_nxt.auxEn         = 6'h00;
      acqCfg_nxt.diagSel       = 8'h00;
      // (RQ5) (RQ14) alternate path, one sample
      acqCfg_nxt.altPath       = 1'b1;
      acqCfg_nxt.ovSample      = 4'h0;
      acqCfg_nxt.bipolar       = 1'b1;
    end
  end
  // register stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scan_config_r  <= 3'h0;
      altUser_r  <= 1'b0;
      ovsUser_r  <= 4'h0;
      swUser_r   <= 14'h0000;
      polarity_r <= 14'h0000;
      cellUser_r <= RST_CELL_EN;
      auxUser_r  <= 6'h00;
      diagUser_r <= 8'h00;
      lowThr_r   <= RST_LOW_THR;
      highThr_r  <= RST_HIGH_THR;
      highest_cell_position_r  <= RST_TOP_CELL;
      alerts_r   <= 14'h0000;
      summary_r  <= 1'b0;
      irqStat_r  <= 2'h0;
      irqMask_r  <= 2'h0;
      state_r    <= ST_IDLE;
      scanMode_r <= 3'h0;
      pending_r  <= 14'h0000;
      doneFlag_r <= 1'b0;
      scanReq_r  <= 1'b0;
      acqCfg_r   <= '0;
      ack_r      <= 1'b0;
      rdata_r    <= 32'h0000_0000;
    end else begin
      scan_config_r  <= scan_config_nxt;
      altUser_r  <= altUser_nxt;
      ovsUser_r  <= ovsUser_nxt;
      swUser_r   <= swUser_nxt;
      polarity_r <= polarity_nxt;
      cellUser_r <= cellUser_nxt;
      auxUser_r  <= auxUser_nxt;
      diagUser_r <= diagUser_nxt;
      lowThr_r   <= lowThr_nxt;
      highThr_r  <= highThr_nxt;
      highest_cell_position_r  <= highest_cell_position_nxt;
      alerts_r   <= alerts_nxt;
      summary_r  <= summary_nxt;
      irqStat_r  <= irqStat_nxt;
      irqMask_r  <= irqMask_nxt;
      state_r    <= state_nxt;
      scanMode_r <= scanMode_nxt;
      pending_r  <= pending_nxt;
      doneFlag_r <= doneFlag_nxt;
      scanReq_r  <= scanReq_nxt;
      acqCfg_r   <= acqCfg_nxt;
      ack_r      <= ack_nxt;
      rdata_r    <= rdata_nxt;
    end
  end
  // checks beside the logic
  bus_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
    busReq && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  cell_force_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ3
    state_r == ST_SCAN && bsod_is_diag(scanMode_r)
    |-> acqCfg_r.cellEn[13:0] == (acqCfg_r.swEn & ~polarity_r))
    else $error("cell enables not forced from switch mask");
  meas_off_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
    state_r == ST_SCAN && bsod_is_diag(scanMode_r)
    |-> acqCfg_r.cellEn[15:14] == 2'b00 && acqCfg_r.auxEn == 6'h00
        && acqCfg_r.diagSel == 8'h00)
    else $error("block, aux or selectors not forced off");
  alt_path_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
    state_r == ST_SCAN && bsod_is_diag(scanMode_r)
    |-> acqCfg_r.altPath && acqCfg_r.ovSample == 4'h0)
    else $error("alternate path or single sample missing");
  odd_pattern_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ8
    state_r == ST_SCAN && scanMode_r == CFG_ODD && scan_config_r == CFG_ODD
    |-> acqCfg_r.swEn == (SW_ODD_PAT & ~$past(polarity_r) & $past(topMask))
        && acqCfg_r.bipolar)
    else $error("odd switch pattern wrong");
  restore_cfg_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ15
    state_r == ST_DONE |=> acqCfg_r.diagSel == diagUser_r
    && acqCfg_r.auxEn == auxUser_r
    && acqCfg_r.ovSample == ovsUser_r)
    else $error("user settings not restored after scan");
  alert_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ17
    startPulse && bsod_is_diag(scan_config_nxt) |=> alerts_r == 14'h0000)
    else $error("alerts not cleared at scan request");
  summary_or_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ18
    state_r == ST_DONE && bsod_is_diag(scanMode_r)
    |=> summary_r == |alerts_r && alerts_r == $past(pending_r))
    else $error("summary or alerts not written at end");
  high_fault_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ1
    result.valid && state_r == ST_SCAN && bsod_is_diag(scanMode_r)
    && result.channel < 4'hd + 4'h1 && acqCfg_r.cellEn[result.channel]
    && result.data > highThr_r |=> pending_r[$past(result.channel)])
    else $error("high threshold fault not recorded");
  window_pass_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ2
    result.valid && result.data >= lowThr_r && result.data <= highThr_r
    |-> faultHit == 14'h0000)
    else $error("in-window result raised a fault");
  unmeasured_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ19
    (faultHit & ~acqCfg_r.cellEn[13:0]) == 14'h0000)
    else $error("unmeasured channel raised a fault");
endmodule

// ### rtl/bsod_pkg.sv
package bsod_pkg;
  // channel and data sizes
  localparam int NUM_CH = 14;
  localparam int DATA_W = 14;
  // register byte offsets
  localparam logic [5:0] OFF_SCAN_CTRL = 6'h00;
  localparam logic [5:0] OFF_SW_EN     = 6'h04;
  localparam logic [5:0] OFF_POLARITY  = 6'h08;
  localparam logic [5:0] OFF_CELL_EN   = 6'h0c;
  localparam logic [5:0] OFF_AUX_EN    = 6'h10;
  localparam logic [5:0] OFF_DIAG_SEL  = 6'h14;
  localparam logic [5:0] OFF_LOW_THR   = 6'h18;
  localparam logic [5:0] OFF_HIGH_THR  = 6'h1c;
  localparam logic [5:0] OFF_TOP_CELL  = 6'h20;
  localparam logic [5:0] OFF_ALERTS    = 6'h24;
  localparam logic [5:0] OFF_IRQ_STAT  = 6'h28;
  localparam logic [5:0] OFF_IRQ_MASK  = 6'h2c;
  // scan control, alert and irq field positions
  localparam int SC_CFG_LSB   = 0;
  localparam int SC_ALT_BIT   = 3;
  localparam int SC_OVS_LSB   = 4;
  localparam int SC_START_BIT = 8;
  localparam int SC_BUSY_BIT  = 9;
  localparam int SC_DONE_BIT  = 10;
  localparam int ALERT_SUM_BIT = 16;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_FAULT_BIT = 1;
  // scan configuration codes
  localparam logic [2:0] CFG_SW_OPEN = 3'h5;
  localparam logic [2:0] CFG_ODD     = 3'h6;
  localparam logic [2:0] CFG_EVEN    = 3'h7;
  // forced switch patterns
  localparam logic [13:0] SW_ODD_PAT  = 14'h1555;
  localparam logic [13:0] SW_EVEN_PAT = 14'h2aaa;
  // reset values
  localparam logic [13:0] RST_LOW_THR  = 14'h0000;
  localparam logic [13:0] RST_HIGH_THR = 14'h3fff;
  localparam logic [3:0]  RST_TOP_CELL = 4'hd;
  localparam logic [15:0] RST_CELL_EN  = 16'h3fff;
  // scan sequencer states, gray along idle-scan-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_DONE = 2'b11
  } bsod_state_e;
  // effective acquisition settings toward the acquisition engine
  typedef struct packed {
    logic [15:0] cellEn;
    logic [5:0]  auxEn;
    logic [7:0]  diagSel;
    logic        altPath;
    logic [3:0]  ovSample;
    logic [13:0] swEn;
    logic        bipolar;
  } bsod_acq_cfg_s;
  // one channel result from the acquisition engine
  typedef struct packed {
    logic        valid;
    logic [3:0]  channel;
    logic [13:0] data;
  } bsod_result_s;
  // any of the three switch diagnostic modes handled here
  function automatic logic bsod_is_diag(input logic [2:0] c);
    return (c == CFG_SW_OPEN) || (c == CFG_ODD) || (c == CFG_EVEN);
  endfunction
  // sense-wire open modes only
  function automatic logic bsod_is_sense(input logic [2:0] c);
    return (c == CFG_ODD) || (c == CFG_EVEN);
  endfunction
endpackage

// ### test/tb_balance_switch_open_diag.sv
`timescale 1ns/10ps
module tb_balance_switch_open_diag
  import bsod_pkg::*;
;
  logic          clk;            // core clock
  logic          reset_n;        // sync reset
  logic [5:0]    avsAddress;     // bus address
  logic          avsRead;        // bus read
  logic          avsWrite;       // bus write
  logic [31:0]   avsWritedata;   // bus write data
  logic [31:0]   avsReaddata;    // bus read data
  logic          avsWaitrequest; // bus stall
  logic          irq;            // interrupt level
  bsod_acq_cfg_s acqCfg;         // effective settings
  logic          scanRequest;    // scan start pulse
  bsod_result_s  result;         // channel result
  logic          acqDone;        // engine done
  int            failures;       // mismatches
  int            checks;         // comparisons
  int            cycles;         // hang guard count
  integer        seed;           // random seed
  logic [1:0]    irqMask;        // mask as written
  logic [16:0]   alertsExp;      // expected alert word
  logic [13:0]   chData [14];    // per channel data
  logic [31:0]   rd;             // last read word
  logic [31:0]   x;              // random draw
  logic [2:0]    modes [8];      // scan codes to run
  logic [5:0]    rstAddr [10];   // reset table places
  logic [31:0]   rstVal [10];    // reset table values

  bsod_diag i_bsod_diag (
    .clk             (clk),
    .reset_n         (reset_n),
    .avs_address     (avsAddress),
    .avs_read        (avsRead),
    .avs_write       (avsWrite),
    .avs_writedata   (avsWritedata),
    .avs_readdata    (avsReaddata),
    .avs_waitrequest (avsWaitrequest),
    .irq             (irq),
    .acqCfg          (acqCfg),
    .scanRequest     (scanRequest),
    .result          (result),
    .acqDone         (acqDone)
  );

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures = failures + 1;
      end_of_test();
    end
  end

  // verdict and stop
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // compare and report
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // wait for the edge with waitrequest low
  task automatic busWait();
    int n;
    n = 0;
    @(posedge clk);
    while (avsWaitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) check("bus answer", 32'h1, 32'h0);
  endtask

  task automatic busWrite(input logic [5:0] a, input logic [31:0] d);
    avsAddress   <= a;
    avsWritedata <= d;
    avsWrite     <= 1'b1;
    busWait();
    avsWrite <= 1'b0;
    @(posedge clk);
  endtask

  task automatic busRead(input logic [5:0] a, output logic [31:0] d);
    avsAddress <= a;
    avsRead    <= 1'b1;
    busWait();
    d = avsReaddata;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [13:0] effSw(input logic [2:0] c,
    input logic [13:0] sw, input logic [13:0] bip, input logic [3:0] t);
    logic [13:0] topMask;
    topMask = 14'h3fff >> (4'hd - t);
    if (c == CFG_ODD) return SW_ODD_PAT & ~bip & topMask;
    if (c == CFG_EVEN) return SW_EVEN_PAT & ~bip & topMask;
    return sw;
  endfunction

  function automatic logic [13:0] expAlerts(input logic [13:0] meas,
    input logic [13:0] lo, input logic [13:0] hi);
    logic [13:0] a;
    a = 14'h0;
    for (int i = 0; i < 14; i++)
      if (meas[i] && (chData[i] < lo || chData[i] > hi)) a[i] = 1'b1;
    return a;
  endfunction

  // one full scan with random settings and data
  task automatic runScan(input logic [2:0] c, input logic [13:0] bip,
                         input logic [3:0] t);
    logic [13:0] sw, lo, hi, sws, meas, al;
    logic [15:0] cen;
    logic [5:0]  aux;
    logic [7:0]  dsel;
    logic [3:0]  ovs;
    logic        diag;
    int          n;
    diag = (c == CFG_SW_OPEN || c == CFG_ODD || c == CFG_EVEN);
    al   = 14'h0;
    x    = $random(seed);
    lo   = {3'b001, x[10:0]};
    hi   = {2'b10, x[22:11]};
    ovs  = x[26:23] | 4'h1;
    aux  = x[31:26];
    x    = $random(seed);
    sw   = x[13:0];
    cen  = x[29:14];
    dsel = {x[31:30], x[5:0]};
    // boundary and random results
    for (int i = 0; i < 14; i++) begin
      x = $random(seed);
      case (x[2:0])
        3'h0: chData[i] = lo - 14'h1;
        3'h1: chData[i] = lo;
        3'h2: chData[i] = hi;
        3'h3: chData[i] = hi + 14'h1;
        default: chData[i] = x[16:3];
      endcase
    end
    busWrite(OFF_SW_EN, {18'h0, sw});
    busWrite(OFF_POLARITY, {18'h0, bip});
    busWrite(OFF_TOP_CELL, {28'h0, t});
    busWrite(OFF_LOW_THR, {18'h0, lo});
    busWrite(OFF_HIGH_THR, {18'h0, hi});
    busWrite(OFF_CELL_EN, {16'h0, cen});
    busWrite(OFF_AUX_EN, {26'h0, aux});
    busWrite(OFF_DIAG_SEL, {24'h0, dsel});
    busWrite(OFF_SCAN_CTRL, {24'h0, ovs, 1'b0, c});
    if (c == CFG_ODD || c == CFG_EVEN) repeat (5000) @(posedge clk);
    busWrite(OFF_SCAN_CTRL, {23'h0, 1'b1, ovs, 1'b0, c});
    for (n = 0; n < 20 && scanRequest !== 1'b1; n++) @(posedge clk);
    check("scan request", {31'h0, scanRequest}, 32'h1);
    sws  = effSw(c, sw, bip, t);
    meas = sws & ~bip;
    if (diag) begin
      check("cell enables", {16'h0, acqCfg.cellEn}, {18'h0, meas});
      check("aux and diag", {18'h0, acqCfg.auxEn, acqCfg.diagSel}, 32'h0);
      check("path and ovs", {27'h0, acqCfg.altPath, acqCfg.ovSample}, 32'h10);
      check("switch enables", {18'h0, acqCfg.swEn}, {18'h0, sws});
      check("bipolar", {31'h0, acqCfg.bipolar}, 32'h1);
      alertsExp[13:0] = 14'h0;
    end else begin
      check("plain cell enables", {16'h0, acqCfg.cellEn}, {16'h0, cen});
    end
    busRead(OFF_SCAN_CTRL, rd);
    check("busy", {30'h0, rd[10:9]}, 32'h1);
    busRead(OFF_ALERTS, rd);
    check("alerts at start", {18'h0, rd[13:0]}, {18'h0, alertsExp[13:0]});
    for (int i = 0; i < 14; i++) begin
      result <= '{valid: 1'b1, channel: 4'(i), data: chData[i]};
      @(posedge clk);
    end
    result <= '{valid: 1'b1, channel: 4'hf, data: 14'h0};
    @(posedge clk);
    result.valid <= 1'b0;
    acqDone      <= 1'b1;
    @(posedge clk);
    acqDone <= 1'b0;
    repeat (3) @(posedge clk);
    check("user cell enables", {16'h0, acqCfg.cellEn}, {16'h0, cen});
    check("user path", {27'h0, acqCfg.altPath, acqCfg.ovSample}, {28'h0, ovs});
    check("user aux", {18'h0, acqCfg.auxEn, acqCfg.diagSel}, {18'h0, aux, dsel});
    if (diag) begin
      al        = expAlerts(meas, lo, hi);
      alertsExp = {|al, 2'b00, al};
    end
    busRead(OFF_ALERTS, rd);
    check("alerts", rd, {15'h0, alertsExp});
    busRead(OFF_SCAN_CTRL, rd);
    check("scan control", rd, {21'h0, 3'b100, ovs, 1'b0, c});
    busRead(OFF_IRQ_STAT, rd);
    check("irq status", rd, {30'h0, diag & (|al), 1'b1});
    check("irq level", {31'h0, irq}, {31'h0, |({|al, 1'b1} & irqMask)});
    busWrite(OFF_IRQ_STAT, 32'h3);
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  // main sequence
  initial begin
    seed         = 32'h2771ad91;
    failures     = 0;
    checks       = 0;
    cycles       = 0;
    reset_n      = 1'b0;
    avsAddress   = 6'h0;
    avsRead      = 1'b0;
    avsWrite     = 1'b0;
    avsWritedata = 32'h0;
    result       = '0;
    acqDone      = 1'b0;
    alertsExp    = 17'h0;
    modes   = '{CFG_SW_OPEN, CFG_ODD, CFG_EVEN, CFG_ODD, CFG_EVEN,
                CFG_SW_OPEN, 3'h0, 3'h4};
    rstAddr = '{OFF_SCAN_CTRL, OFF_SW_EN, OFF_POLARITY, OFF_CELL_EN,
                OFF_LOW_THR, OFF_HIGH_THR, OFF_TOP_CELL, OFF_ALERTS,
                OFF_IRQ_STAT, 6'h3c};
    rstVal  = '{32'h0, 32'h0, 32'h0, 32'h3fff, 32'h0, 32'h3fff,
                32'hd, 32'h0, 32'h0, 32'h0};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    // first edge out of reset loads user values, look one edge later
    repeat (2) @(posedge clk);
    check("reset cell enables", {16'h0, acqCfg.cellEn}, 32'h3fff);
    // unmapped write ignored, reads zero
    busWrite(6'h3c, 32'hffffffff);
    for (int i = 0; i < 10; i++) begin
      busRead(rstAddr[i], rd);
      check("reset value", rd, rstVal[i]);
    end
    $display("test reset finished");
    irqMask = 2'h3;
    busWrite(OFF_IRQ_MASK, 32'h3);
    for (int i = 0; i < 8; i++) begin
      x = $random(seed);
      if (i == 6) begin
        irqMask = 2'h0;
        busWrite(OFF_IRQ_MASK, 32'h0);
      end
      runScan(modes[i], (i < 3) ? 14'h0 : x[13:0],
              (i < 3 || i == 5) ? 4'hd : {1'b0, x[16:14]} + 4'h4);
      $display("test scan %0d finished", i);
    end
    // summary write one kept, write zero clears
    busWrite(OFF_ALERTS, 32'h00010000);
    busRead(OFF_ALERTS, rd);
    check("summary kept", rd, {15'h0, alertsExp});
    busWrite(OFF_ALERTS, 32'h0);
    alertsExp[16] = 1'b0;
    busRead(OFF_ALERTS, rd);
    check("summary cleared", rd, {15'h0, alertsExp});
    $display("test summary finished");
    end_of_test();
  end
endmodule
